//--- include/hpp_pkg.sv
// Package for the host processor port: pin widths, modes, FSM states, pin levels
// and the request carrier handed to the user logic.
// Assumes a single system clock domain; the host bus clock is sampled as data.
package hpp_pkg;

    // ******************************************************************
    // Widths
    // ******************************************************************
    localparam int PIN_ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int USR_ADDR_W = 8;
    localparam int BE_W = 2;
    localparam int HI_ADDR_LSB = 2;
    localparam int SYNC_W = 4 + PIN_ADDR_W + DATA_W;

    // ******************************************************************
    // Pin levels
    // ******************************************************************
    // Burst inhibit is held asserted in the first mode and left undriven in the second: this port never serves bursts
    localparam logic BI_ASSERT = 1'b0;
    localparam logic TA_ASSERT = 1'b1;
    localparam logic RDY_ASSERT = 1'b0;
    localparam logic IRQ_IDLE = 1'b1;
    localparam logic STRB_ACTIVE = 1'b0;
    localparam logic MODE_FIRST = 1'b0;
    localparam logic MODE_SECOND = 1'b1;
    localparam logic [USR_ADDR_W-PIN_ADDR_W-1:0] ADDR_PAD = 3'h0;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [1:0] {
        HPP_IDLE = 2'h0,
        HPP_DATA = 2'h1,
        HPP_USER = 2'h3,
        HPP_ACK = 2'h2
    } hpp_state_t;

    typedef struct packed {
        logic [USR_ADDR_W-1:0] addr;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } hpp_req_t;

    // Order of bits in the synchroniser bundle, high to low
    typedef struct packed {
        logic clk;
        logic strobe;
        logic ale;
        logic rw;
        logic [PIN_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hpp_pins_t;

endpackage

//--- hdl/hpp_sync.sv
// Multi-bit two-stage synchroniser for the host port pins.
// Assumes each bit is an independent level; bursts of skew are absorbed by the
// host bus clock edge detection downstream.
`timescale 1ns/1ps
module hpp_sync #(
    parameter int W = 1,
    parameter int STAGES = 2
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [STAGES-1:0][W-1:0] chain;

    // Refused at elaboration: one stage would let a metastable level into the logic
    if (STAGES < 2 || W < 1) begin : g_bad_params
        $error("hpp_sync: needs W >= 1 and STAGES >= 2");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], d_i};
        end
    end

    assign q_o = chain[STAGES-1];
endmodule // hpp_sync

//--- hdl/hpp_port.sv
// Host processor port: synchronous parallel slave towards an external processor
// that runs in one of two bus modes, turning pin cycles into user requests.
// Assumes the host bus clock is much slower than clk_sys_i (at least 8 cycles per
// period) so that its edges can be found after synchronising.
`timescale 1ns/1ps
module hpp_port (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Configuration
    input wire logic port_en_i,
    input wire logic mode_i,
    // Host pins
    input wire logic host_bus_clock_i,
    input wire logic transfer_strobe_i,
    input wire logic addr_latch_enable_i,
    input wire logic read_write_sel_i,
    input wire logic [hpp_pkg::PIN_ADDR_W-1:0] addr_i,
    input wire logic [hpp_pkg::DATA_W-1:0] data_i,
    output logic [hpp_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic host_interrupt_req_n_o,
    output logic burst_inhibit_out_o,
    output logic burst_inhibit_oe_o,
    output logic transfer_ack_out_o,
    output logic transfer_ack_oe_o,
    // User side
    output logic usr_req_o,
    output hpp_pkg::hpp_req_t usr_req_data_o,
    input wire logic usr_done_i,
    input wire logic [hpp_pkg::DATA_W-1:0] usr_rdata_i,
    input wire logic usr_irq_i,
    input wire logic usr_bi_o_i,
    input wire logic usr_bi_oe_i,
    input wire logic usr_ack_o_i,
    input wire logic usr_ack_oe_i
);

    // ******************************************************************
    // State
    // ******************************************************************
    typedef struct packed {
        hpp_pkg::hpp_state_t st;
        logic clk_prev;
        hpp_pkg::hpp_req_t req;
        logic req_pulse;
        logic [hpp_pkg::USR_ADDR_W-1-hpp_pkg::HI_ADDR_LSB:0] ale_addr;
        logic [hpp_pkg::DATA_W-1:0] rdata;
        logic ack_on;
        logic drive_d;
        logic irq_n;
    } hpp_regs_t;

    localparam hpp_regs_t RESET_REGS = '{
        st: hpp_pkg::HPP_IDLE,
        clk_prev: 1'b0,
        req: '0,
        req_pulse: 1'b0,
        ale_addr: '0,
        rdata: '0,
        ack_on: 1'b0,
        drive_d: 1'b0,
        irq_n: hpp_pkg::IRQ_IDLE
    };

    hpp_regs_t q;
    hpp_regs_t next_q;
    hpp_pkg::hpp_pins_t pins_s;
    logic host_rise;
    logic start;
    logic second;

    // ******************************************************************
    // Pin synchronisation
    // ******************************************************************
    hpp_sync #(
        .W(hpp_pkg::SYNC_W),
        .STAGES(2)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .d_i({host_bus_clock_i, transfer_strobe_i, addr_latch_enable_i, read_write_sel_i, addr_i, data_i}),
        .q_o(pins_s)
    );

    // Host clock is sampled, never used as a clock: no second domain to cross
    assign host_rise = pins_s.clk && !q.clk_prev;
    assign second = (mode_i == hpp_pkg::MODE_SECOND);
    assign start = port_en_i && host_rise && (q.st == hpp_pkg::HPP_IDLE)
        && (pins_s.strobe == hpp_pkg::STRB_ACTIVE);

    // ******************************************************************
    // Address forming
    // ******************************************************************
    function automatic logic [hpp_pkg::USR_ADDR_W-1:0] form_addr(
        input logic mode2,
        input logic [hpp_pkg::PIN_ADDR_W-1:0] a,
        input logic [hpp_pkg::USR_ADDR_W-1-hpp_pkg::HI_ADDR_LSB:0] hi
    );
        if (mode2) begin
            form_addr = {hi, a[hpp_pkg::BE_W-1:0]};
        end else begin
            form_addr = {hpp_pkg::ADDR_PAD, a};
        end
    endfunction

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb begin
        logic [hpp_pkg::USR_ADDR_W-1-hpp_pkg::HI_ADDR_LSB:0] hi;
        hi = q.ale_addr;
        next_q = q;
        next_q.clk_prev = pins_s.clk;
        next_q.req_pulse = 1'b0;
        if (host_rise) begin
            next_q.irq_n = !usr_irq_i;
        end
        // Address phase on the shared data lines
        if (port_en_i && second && host_rise && pins_s.ale) begin
            hi = pins_s.data[hpp_pkg::DATA_W-1:hpp_pkg::HI_ADDR_LSB];
            next_q.ale_addr = hi;
        end
        case (q.st)
            hpp_pkg::HPP_IDLE: begin
                if (start) begin
                    next_q.req.addr = form_addr(second, pins_s.addr, hi);
                    next_q.req.wr = second ? pins_s.rw : !pins_s.rw;
                    next_q.st = hpp_pkg::HPP_DATA;
                end
            end
            hpp_pkg::HPP_DATA: begin
                if (host_rise) begin
                    next_q.req.wdata = pins_s.data;
                    next_q.req_pulse = 1'b1;
                    next_q.st = hpp_pkg::HPP_USER;
                end
            end
            hpp_pkg::HPP_USER: begin
                if (usr_done_i) begin
                    next_q.rdata = usr_rdata_i;
                    next_q.st = hpp_pkg::HPP_ACK;
                end
            end
            hpp_pkg::HPP_ACK: begin
                // Acknowledge spans exactly one host clock period
                if (host_rise) begin
                    if (!q.ack_on) begin
                        next_q.ack_on = 1'b1;
                        next_q.drive_d = !q.req.wr;
                    end else begin
                        next_q.ack_on = 1'b0;
                        next_q.drive_d = 1'b0;
                        next_q.st = hpp_pkg::HPP_IDLE;
                    end
                end
            end
            default: begin
                next_q.st = hpp_pkg::HPP_IDLE;
            end
        endcase
        // Dropping the port abandons the access in flight, except a user request whose data phase is sampled in that same cycle
        if (!port_en_i) begin
            next_q.st = hpp_pkg::HPP_IDLE;
            next_q.ack_on = 1'b0;
            next_q.drive_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            q <= RESET_REGS;
        end else begin
            q <= next_q;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    assign usr_req_o = q.req_pulse;
    assign usr_req_data_o = q.req;
    assign host_interrupt_req_n_o = q.irq_n;
    assign data_o = q.rdata;
    assign data_oe_o = port_en_i && q.drive_d;

    always_comb begin
        if (port_en_i) begin
            burst_inhibit_out_o = hpp_pkg::BI_ASSERT;
            burst_inhibit_oe_o = !second;
            transfer_ack_oe_o = 1'b1;
            if (second) begin
                transfer_ack_out_o = q.ack_on ? hpp_pkg::RDY_ASSERT : !hpp_pkg::RDY_ASSERT;
            end else begin
                transfer_ack_out_o = q.ack_on ? hpp_pkg::TA_ASSERT : !hpp_pkg::TA_ASSERT;
            end
        end else begin
            burst_inhibit_out_o = usr_bi_o_i;
            burst_inhibit_oe_o = usr_bi_oe_i;
            transfer_ack_out_o = usr_ack_o_i;
            transfer_ack_oe_o = usr_ack_oe_i;
        end
    end

    // ******************************************************************
    // Assertions
    // ******************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_start;
        start;
    endsequence

    sequence s_req;
        ##[1:40] usr_req_o;
    endsequence

    property p_irq;
        host_rise |=> host_interrupt_req_n_o == !$past(usr_irq_i);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin not updated on host edge");

    property p_irq_hold;
        !host_rise |=> $stable(host_interrupt_req_n_o);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt pin moved between host edges");

    property p_ale;
        port_en_i && second && host_rise && pins_s.ale
            |=> q.ale_addr == $past(pins_s.data[hpp_pkg::DATA_W-1:hpp_pkg::HI_ADDR_LSB]);
    endproperty
    a_ale: assert property (p_ale) else $error("address phase not latched on address latch enable");

    property p_bi;
        port_en_i && !second |-> burst_inhibit_oe_o && burst_inhibit_out_o == hpp_pkg::BI_ASSERT;
    endproperty
    a_bi: assert property (p_bi) else $error("burst inhibit not asserted");

    property p_ta;
        port_en_i && !second && q.ack_on |-> transfer_ack_oe_o && transfer_ack_out_o;
    endproperty
    a_ta: assert property (p_ta) else $error("first mode acknowledge not high");

    property p_rdy;
        port_en_i && second && q.ack_on |-> transfer_ack_oe_o && !transfer_ack_out_o;
    endproperty
    a_rdy: assert property (p_rdy) else $error("second mode acknowledge not low");

    property p_wr1;
        s_start and !second |=> usr_req_data_o.wr == !$past(pins_s.rw);
    endproperty
    a_wr1: assert property (p_wr1) else $error("first mode write decode wrong");

    property p_wr2;
        s_start and second |=> usr_req_data_o.wr == $past(pins_s.rw);
    endproperty
    a_wr2: assert property (p_wr2) else $error("second mode write decode wrong");

    property p_ack_edge;
        $changed(q.ack_on) && port_en_i |-> $past(host_rise);
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("acknowledge moved off a host edge");

    property p_addr1;
        s_start and !second |=> usr_req_data_o.addr == {hpp_pkg::ADDR_PAD, $past(pins_s.addr)};
    endproperty
    a_addr1: assert property (p_addr1) else $error("first mode address mapping wrong");

    property p_addr2;
        s_start and second |=> usr_req_data_o.addr[hpp_pkg::BE_W-1:0] == $past(pins_s.addr[1:0])
            && usr_req_data_o.addr[hpp_pkg::USR_ADDR_W-1:hpp_pkg::HI_ADDR_LSB] == q.ale_addr;
    endproperty
    a_addr2: assert property (p_addr2) else $error("second mode address forming wrong");

    property p_release;
        !port_en_i |-> transfer_ack_oe_o == usr_ack_oe_i && burst_inhibit_oe_o == usr_bi_oe_i;
    endproperty
    a_release: assert property (p_release) else $error("pins not released to user");

    property p_strobe;
        s_start |-> s_req;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe did not raise a user request");

    property p_data_oe;
        data_oe_o |-> q.ack_on && !q.req.wr;
    endproperty
    a_data_oe: assert property (p_data_oe) else $error("data lines driven outside read acknowledge");

endmodule // hpp_port

//--- testbench/hpp_host_model.sv
// Partner model: an external processor driving the synchronous host bus.
// Assumes the bench resolves the shared data lines and hands their level back on bus_i.
`timescale 1ns/1ps
module hpp_host_model (
    input wire logic mode_i,
    input wire logic ack_i,
    input wire logic ack_oe_i,
    input wire logic [hpp_pkg::DATA_W-1:0] bus_i,
    output logic host_bus_clock_o,
    output logic strobe_n_o,
    output logic ale_o,
    output logic rw_o,
    output logic [hpp_pkg::PIN_ADDR_W-1:0] addr_o,
    output logic [hpp_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o
);
    initial begin
        host_bus_clock_o = 1'b0;
        strobe_n_o = 1'b1;
        ale_o = 1'b0;
        rw_o = 1'b1;
        addr_o = 5'h00;
        data_o = 8'h00;
        data_oe_o = 1'b0;
    end

    // Free running, odd start offset keeps it out of phase with the system clock
    initial begin
        #137;
        forever #400 host_bus_clock_o = ~host_bus_clock_o;
    end

    // Pins move on the falling edge so each one is settled at the sampling rise
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] hi, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
        int n;
        @(negedge host_bus_clock_o);
        strobe_n_o <= 1'b0;
        ale_o <= mode_i;
        rw_o <= mode_i ? wr : !wr;
        addr_o <= a;
        data_o <= mode_i ? hi : wd;
        data_oe_o <= 1'b1;
        @(negedge host_bus_clock_o);
        strobe_n_o <= 1'b1;
        ale_o <= 1'b0;
        data_o <= wr ? wd : ~data_o;
        data_oe_o <= wr;
        ok = 1'b0;
        rd = 8'h00;
        for (n = 0; n < 24 && ok !== 1'b1; n++) begin
            @(posedge host_bus_clock_o);
            if (ack_oe_i === 1'b1 && ack_i === (mode_i ? hpp_pkg::RDY_ASSERT : hpp_pkg::TA_ASSERT)) begin
                ok = 1'b1;
                rd = bus_i;
            end
        end
        // Released lines show the inverse of their last value, never a stale copy
        @(negedge host_bus_clock_o);
        data_o <= ~data_o;
        data_oe_o <= 1'b0;
        @(posedge host_bus_clock_o);
    endtask
endmodule // hpp_host_model

//--- testbench/testbench.sv
// Self-checking bench for hpp_port: host model on the pins, bench acts as user logic.
// Assumes hpp_pkg is compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic port_en_i = 1'b1;
    logic mode_i = 1'b0;
    logic usr_done_i = 1'b0;
    logic [7:0] usr_rdata_i = 8'h00;
    logic usr_irq_i = 1'b0;
    logic [3:0] gpio = 4'h0;
    wire hclk, strb_n, ale, rw, hoe, dut_oe, irq_n, bi, bi_oe, ack, ack_oe, usr_req;
    wire [4:0] haddr;
    wire [7:0] hdata, dut_data, bus;
    hpp_pkg::hpp_req_t req_data;
    hpp_pkg::hpp_req_t got;
    logic [7:0] rdat = 8'h00;
    int err_total = 0;
    int n_tests = 0;
    int n_req = 0;
    int user_dly = 0;

    assign bus = dut_oe ? dut_data : hdata;
    always #50 clk_sys_i = ~clk_sys_i;

    hpp_port DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .port_en_i(port_en_i), .mode_i(mode_i),
        .host_bus_clock_i(hclk), .transfer_strobe_i(strb_n), .addr_latch_enable_i(ale),
        .read_write_sel_i(rw), .addr_i(haddr), .data_i(bus), .data_o(dut_data), .data_oe_o(dut_oe),
        .host_interrupt_req_n_o(irq_n), .burst_inhibit_out_o(bi), .burst_inhibit_oe_o(bi_oe),
        .transfer_ack_out_o(ack), .transfer_ack_oe_o(ack_oe), .usr_req_o(usr_req),
        .usr_req_data_o(req_data), .usr_done_i(usr_done_i), .usr_rdata_i(usr_rdata_i),
        .usr_irq_i(usr_irq_i), .usr_bi_o_i(gpio[0]), .usr_bi_oe_i(gpio[1]), .usr_ack_o_i(gpio[2]),
        .usr_ack_oe_i(gpio[3]));

    hpp_host_model host (.mode_i(mode_i), .ack_i(ack), .ack_oe_i(ack_oe), .bus_i(bus),
        .host_bus_clock_o(hclk), .strobe_n_o(strb_n), .ale_o(ale), .rw_o(rw), .addr_o(haddr),
        .data_o(hdata), .data_oe_o(hoe));

    // ****************************************************************
    // User side responder, prompt or slow as user_dly says
    // ****************************************************************
    always begin
        @(posedge clk_sys_i);
        #1;
        if (usr_req === 1'b1) begin
            got = req_data;
            n_req++;
            repeat (user_dly) begin
                @(posedge clk_sys_i);
                #1;
            end
            usr_done_i = 1'b1;
            usr_rdata_i = rdat;
            @(posedge clk_sys_i);
            #1 usr_done_i = 1'b0;
        end
    end

    // Host and port must never drive the shared lines together
    always @(negedge clk_sys_i) begin
        if (dut_oe === 1'b1) `CHK(hoe, 1'b0)
    end

    task automatic finish_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic do_reset(input logic m);
        @(posedge clk_sys_i);
        #1 srst_i = 1'b1;
        mode_i = m;
        repeat (6) @(posedge clk_sys_i);
        #1 srst_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    // One host access, judged on both the user side and the pins
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] hi, input logic [7:0] v);
        logic [7:0] rd;
        logic ok;
        int base;
        base = n_req;
        // Differs from anything the released host lines can show
        rdat = v ^ 8'h5a;
        host.xfer(wr, a, hi, v, rd, ok);
        if (ok !== 1'b1) begin
            err_total++;
            finish_test();
        end
        `CHK(n_req, base + 1)
        `CHK(got.wr, wr)
        `CHK(got.addr, mode_i ? {hi[7:2], a[1:0]} : {hpp_pkg::ADDR_PAD, a})
        if (wr) `CHK(got.wdata, v)
        else `CHK(rd, v ^ 8'h5a)
    endtask

    task automatic t_mode0();
        logic [4:0] a;
        do_reset(1'b0);
        `CHK({bi, bi_oe}, {hpp_pkg::BI_ASSERT, 1'b1})
        `CHK({ack, ack_oe}, {~hpp_pkg::TA_ASSERT, 1'b1})
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h10 : 5'h1f;
            user_dly = (i % 2) * 12;
            xfer(1'b1, a, 8'h00, 8'h5a ^ {3'h0, a});
            xfer(1'b0, a, 8'h00, 8'hc3 ^ {3'h0, a});
        end
    endtask

    task automatic t_mode1();
        do_reset(1'b1);
        `CHK(bi_oe, 1'b0)
        `CHK({ack, ack_oe}, {~hpp_pkg::RDY_ASSERT, 1'b1})
        for (int i = 0; i < 4; i++) begin
            user_dly = i * 5;
            // Upper address pins and low latched bits carry junk that must be dropped
            xfer(1'b1, {3'(7 - i), 2'(i)}, {6'(i * 9 + 5), 2'(3 - i)}, 8'h31 + 8'(i));
            xfer(1'b0, {3'(i + 1), 2'(3 - i)}, {6'(i * 7 + 33), 2'(i)}, 8'h96 - 8'(i));
        end
    endtask

    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 40 && irq_n !== lvl; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (irq_n !== lvl) begin
            err_total++;
            finish_test();
        end
        `CHK(irq_n, lvl)
    endtask

    task automatic t_irq();
        @(posedge clk_sys_i);
        #1 usr_irq_i = 1'b1;
        wait_irq(1'b0);
        usr_irq_i = 1'b0;
        wait_irq(hpp_pkg::IRQ_IDLE);
    endtask

    // Port out of use: released pins follow the user drive
    task automatic t_release();
        @(posedge clk_sys_i);
        #1 port_en_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            gpio = (i == 0) ? 4'h5 : (i == 1) ? 4'ha : (i == 2) ? 4'hf : 4'h0;
            repeat (2) @(posedge clk_sys_i);
            `CHK({bi, bi_oe, ack, ack_oe}, {gpio[0], gpio[1], gpio[2], gpio[3]})
            #1;
        end
        port_en_i = 1'b1;
    endtask

    initial begin
        t_mode0();
        t_mode1();
        t_irq();
        t_release();
        finish_test();
    end
endmodule // testbench
